/* csor_regs.vh */
`ifndef CSOR_REGS_VH
`define CSOR_REGS_VH

// ----------------------------------------------------------------------------
// Core data-space mirrors of the status and option registers (9-bit data addresses).
// ----------------------------------------------------------------------------
`define CSOR_STAT_ADDR_B0     9'h003
`define CSOR_STAT_ADDR_B1     9'h083
`define CSOR_STAT_ADDR_B2     9'h103
`define CSOR_STAT_ADDR_B3     9'h183
`define CSOR_OPT_ADDR_B1      9'h081
`define CSOR_OPT_ADDR_B3      9'h181

// ----------------------------------------------------------------------------
// Wishbone word offsets (byte addresses, 32-bit data).
// ----------------------------------------------------------------------------
`define CSOR_WB_STATUS        6'h00
`define CSOR_WB_OPTION        6'h04
`define CSOR_WB_CORE_CTRL     6'h08
`define CSOR_WB_ALU_CTRL      6'h0c
`define CSOR_WB_ALU_RESULT    6'h10
`define CSOR_WB_DERIVED       6'h14

// ----------------------------------------------------------------------------
// Status register field positions.
// ----------------------------------------------------------------------------
`define CSOR_ST_CARRY         0
`define CSOR_ST_NIBBLE        1
`define CSOR_ST_ZERO          2
`define CSOR_ST_PD            3
`define CSOR_ST_TO            4
`define CSOR_ST_RP0           5
`define CSOR_ST_RP1           6
`define CSOR_ST_IRP           7

// ----------------------------------------------------------------------------
// Option register field positions.
// ----------------------------------------------------------------------------
`define CSOR_OP_RATE_LSB      0
`define CSOR_OP_ASSIGN        3
`define CSOR_OP_EDGE_T0       4
`define CSOR_OP_SRC_T0        5
`define CSOR_OP_IRQ_EDGE      6
`define CSOR_OP_PULLUP_DIS    7

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define CSOR_STATUS_RST       8'h18
`define CSOR_OPTION_RST       8'hff

// ----------------------------------------------------------------------------
// ALU operation codes.
// ----------------------------------------------------------------------------
`define CSOR_OP_ADD           3'h0
`define CSOR_OP_SUB           3'h1
`define CSOR_OP_RLF           3'h2
`define CSOR_OP_RRF           3'h3
`define CSOR_OP_LOGIC         3'h4

`endif

/* csor_alu_flags.v */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Flag generator: result and zero, carry, nibble-carry flags of one operation.
// ----------------------------------------------------------------------------
`include "csor_regs.vh"

module csor_alu_flags
(
    input  wire [2:0] op_i,
    input  wire [7:0] a_i,
    input  wire [7:0] b_i,
    input  wire       carry_in_i,
    output reg  [7:0] result_o,
    output reg        zero_o,
    output reg        carry_o,
    output reg        nibble_o,
    output reg        upd_c_o,
    output reg        upd_dc_o
);

    reg [8:0] sum;
    reg [4:0] low;
    reg [7:0] bop;
    reg       cin;

    // Subtraction adds the inverted operand plus a carry in, so both carries
    // read as "no borrow", also when a subtrahend nibble is zero.
    always @*
    begin
        cin      = (op_i == `CSOR_OP_SUB);
        bop      = cin ? ~b_i : b_i; // [R7]
        sum      = {1'b0, a_i} + {1'b0, bop} + {8'h00, cin};
        low      = {1'b0, a_i[3:0]} + {1'b0, bop[3:0]} + {4'h0, cin};
        result_o = sum[7:0];
        carry_o  = sum[8];   // [R7] [R11]
        nibble_o = low[4];   // [R7] [R11]
        upd_c_o  = 1'b1;
        upd_dc_o = 1'b1;
        case (op_i)
            `CSOR_OP_RLF:
            begin
                result_o = {a_i[6:0], carry_in_i};
                carry_o  = a_i[7]; // [R8]
                upd_dc_o = 1'b0;
            end
            `CSOR_OP_RRF:
            begin
                result_o = {carry_in_i, a_i[7:1]};
                carry_o  = a_i[0]; // [R8]
                upd_dc_o = 1'b0;
            end
            `CSOR_OP_LOGIC:
            begin
                result_o = a_i & b_i;
                upd_c_o  = 1'b0;
                upd_dc_o = 1'b0;
            end
            default:
            begin
                upd_c_o  = 1'b1;
            end
        endcase
        zero_o = (result_o == 8'h00);
    end

endmodule // csor_alu_flags

/* csor_core_regs.v */
`timescale 1ns/1ps

`include "csor_regs.vh"

// What this block does
// [R1] Status register answers at 03h, 83h, 103h and 183h, one storage.
// [R2] Option register answers at 81h and 181h, one storage.
// [R3] Every option bit is readable and writable.
// [R4] One prescaler serves either the timer or the watchdog, never both.
// [R5] With prescaler on watchdog the timer counts undivided, 1:1.
// [R6] Option bits pick interrupt edge, timer source and edge, pull-up enable.
// [R7] Subtraction adds the two's complement; carry flags come from that sum.
// [R8] Rotates load carry with the bit shifted out, MSB or LSB.
// [R9] Flag-writing instructions aimed at status keep their own flag result.
// [R10] Writes to timeout and powerdown flags are ignored.
// [R11] In subtraction carry and nibble carry mean no borrow when set.
// [R12] Direct bank from two bank bits, indirect bank from one bit.
// [R13] Rate field divides timer by 2..256 and watchdog by 1..128.
module csor_core_regs
(
    input  wire        clk_i,
    input  wire        rst_i,
    // Classic Wishbone slave.
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [5:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output wire        ack_o,
    // Reset-cause events from watchdog, sleep and kick logic.
    input  wire        wdt_timeout_i,
    input  wire        sleep_i,
    input  wire        watchdog_kick_instr_i,
    // Decoded controls toward timer, watchdog, interrupt and port logic.
    output reg  [8:0]  timer_div_o,
    output reg  [7:0]  watchdog_div_o,
    output reg         ext_irq_edge_o,
    output reg         timer_zero_source_o,
    output reg         timer_zero_edge_o,
    output reg         weak_pullup_en_o,
    output reg  [1:0]  direct_bank_o,
    output reg         indirect_bank_o
);

    // ------------------------------------------------------------------------
    // Functions.
    // ------------------------------------------------------------------------

    // Picks the status register at any of its four bank mirrors.
    function is_status;
        input [8:0] a;
        begin
            is_status = (a == `CSOR_STAT_ADDR_B0) || (a == `CSOR_STAT_ADDR_B1) ||
                        (a == `CSOR_STAT_ADDR_B2) || (a == `CSOR_STAT_ADDR_B3); // [R1]
        end
    endfunction

    // Picks the option register at either of its mirrors.
    function is_option;
        input [8:0] a;
        begin
            is_option = (a == `CSOR_OPT_ADDR_B1) || (a == `CSOR_OPT_ADDR_B3); // [R2]
        end
    endfunction

    // Merges a 32-bit write into a word under its byte enables.
    function [31:0] merge;
        input [31:0] old;
        input [31:0] din;
        input [3:0]  sel;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1)
            begin
                if (sel[k])
                begin
                    merge[8*k +: 8] = din[8*k +: 8];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------------------
    reg  [7:0]  status_r;
    reg  [7:0]  option_r;
    reg  [31:0] core_ctrl_r;   // [8:0] address, [15:8] data, [16] go.
    reg  [31:0] alu_ctrl_r;    // [7:0] a, [15:8] b, [18:16] op, [24] go.
    reg  [7:0]  alu_result_r;
    reg         ack_r;

    wire        req      = cyc_i & stb_i & ~ack_r;
    wire        wr_req   = req & we_i;
    // A go on the core port acts on the address and data of that same access.
    wire [31:0] core_word = merge(core_ctrl_r, dat_i, sel_i);
    wire [8:0]  core_adr  = core_word[8:0];
    wire [7:0]  core_dat  = core_word[15:8];
    wire        core_go  = wr_req && (adr_i == `CSOR_WB_CORE_CTRL) && sel_i[2] && dat_i[16];
    wire        alu_go   = wr_req && (adr_i == `CSOR_WB_ALU_CTRL) && sel_i[3] && dat_i[24];

    wire [7:0]  alu_res;
    wire        alu_z;
    wire        alu_c;
    wire        alu_dc;
    wire        alu_upd_c;
    wire        alu_upd_dc;

    // The go bit launches the operands written in that same access.
    wire [31:0] alu_word = merge(alu_ctrl_r, dat_i, sel_i);

    // ------------------------------------------------------------------------
    // Flag generator.
    // ------------------------------------------------------------------------
    csor_alu_flags u_flags
    (
        .op_i       (alu_word[18:16]),
        .a_i        (alu_word[7:0]),
        .b_i        (alu_word[15:8]),
        .carry_in_i (status_r[`CSOR_ST_CARRY]),
        .result_o   (alu_res),
        .zero_o     (alu_z),
        .carry_o    (alu_c),
        .nibble_o   (alu_dc),
        .upd_c_o    (alu_upd_c),
        .upd_dc_o   (alu_upd_dc)
    );

    // ------------------------------------------------------------------------
    // Bus answer: registered, raised one cycle after the request, dropped the cycle after.
    // ------------------------------------------------------------------------
    assign ack_o = ack_r;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= req;
        end
    end

    // Read data is registered so that it stands with ack.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_o <= 32'h0000_0000;
        end
        else if (req && !we_i)
        begin
            case (adr_i)
                `CSOR_WB_STATUS:     dat_o <= {24'h00_0000, status_r};
                `CSOR_WB_OPTION:     dat_o <= {24'h00_0000, option_r}; // [R3]
                `CSOR_WB_CORE_CTRL:  dat_o <= {16'h0000, core_ctrl_r[15:0]};
                `CSOR_WB_ALU_CTRL:   dat_o <= {13'h0000, alu_ctrl_r[18:0]};
                `CSOR_WB_ALU_RESULT: dat_o <= {24'h00_0000, alu_result_r};
                `CSOR_WB_DERIVED:    dat_o <= {12'h000, indirect_bank_o, direct_bank_o,
                                               watchdog_div_o, timer_div_o};
                default:             dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Control words of the bus-side core access port.
    // ------------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            core_ctrl_r  <= 32'h0000_0000;
            alu_ctrl_r   <= 32'h0000_0000;
            alu_result_r <= 8'h00;
        end
        else
        begin
            if (wr_req && adr_i == `CSOR_WB_CORE_CTRL)
            begin
                core_ctrl_r <= core_word & 32'h0000_ffff;
            end
            if (wr_req && adr_i == `CSOR_WB_ALU_CTRL)
            begin
                alu_ctrl_r <= alu_word & 32'h0007_ffff;
            end
            if (alu_go)
            begin
                alu_result_r <= alu_res;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Status register. Hardware flag updates outrank data writes.
    // ------------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            status_r <= `CSOR_STATUS_RST;
        end
        else
        begin
            // Data write: flags at bits 7..5 and 2..0 only; timeout and powerdown
            // stay untouched by software.
            if (core_go && is_status(core_adr)) // [R1]
            begin
                status_r[`CSOR_ST_IRP] <= core_dat[`CSOR_ST_IRP];
                status_r[`CSOR_ST_RP1] <= core_dat[`CSOR_ST_RP1];
                status_r[`CSOR_ST_RP0] <= core_dat[`CSOR_ST_RP0]; // [R10]
                status_r[`CSOR_ST_ZERO]   <= core_dat[`CSOR_ST_ZERO];
                status_r[`CSOR_ST_NIBBLE] <= core_dat[`CSOR_ST_NIBBLE];
                status_r[`CSOR_ST_CARRY]  <= core_dat[`CSOR_ST_CARRY];
            end
            // Instruction flags win over the data write to the same bits.
            if (alu_go)
            begin
                status_r[`CSOR_ST_ZERO] <= alu_z; // [R9]
                if (alu_upd_c)
                begin
                    status_r[`CSOR_ST_CARRY] <= alu_c; // [R9] [R7] [R8]
                end
                if (alu_upd_dc)
                begin
                    status_r[`CSOR_ST_NIBBLE] <= alu_dc; // [R9] [R11]
                end
            end
            // Reset-cause flags are owned by the watchdog and sleep logic.
            if (watchdog_kick_instr_i)
            begin
                status_r[`CSOR_ST_TO] <= 1'b1; // [R10]
                status_r[`CSOR_ST_PD] <= 1'b1;
            end
            else if (sleep_i)
            begin
                status_r[`CSOR_ST_TO] <= 1'b1;
                status_r[`CSOR_ST_PD] <= 1'b0;
            end
            if (wdt_timeout_i)
            begin
                status_r[`CSOR_ST_TO] <= 1'b0; // [R10]
            end
        end
    end

    // ------------------------------------------------------------------------
    // Option register: fully read/write at both mirrors.
    // ------------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            option_r <= `CSOR_OPTION_RST;
        end
        else if (core_go && is_option(core_adr)) // [R2]
        begin
            option_r <= core_dat; // [R3]
        end
        else if (wr_req && adr_i == `CSOR_WB_OPTION && sel_i[0])
        begin
            option_r <= dat_i[7:0]; // [R3]
        end
    end

    // ------------------------------------------------------------------------
    // Decoded controls. One shared prescaler means the unassigned side runs
    // undivided; the timer can reach 1:1 only by giving it to the watchdog.
    // ------------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timer_div_o         <= 9'h001;
            watchdog_div_o      <= 8'h01;
            ext_irq_edge_o      <= 1'b0;
            timer_zero_source_o <= 1'b0;
            timer_zero_edge_o   <= 1'b0;
            weak_pullup_en_o    <= 1'b0;
            direct_bank_o       <= 2'h0;
            indirect_bank_o     <= 1'b0;
        end
        else
        begin
            if (option_r[`CSOR_OP_ASSIGN])
            begin
                timer_div_o    <= 9'h001; // [R4] [R5]
                watchdog_div_o <= 8'h01 << option_r[2:0]; // [R13]
            end
            else
            begin
                timer_div_o    <= 9'h002 << option_r[2:0]; // [R4] [R13]
                watchdog_div_o <= 8'h01;
            end
            ext_irq_edge_o      <= option_r[`CSOR_OP_IRQ_EDGE];    // [R6]
            timer_zero_source_o <= option_r[`CSOR_OP_SRC_T0];      // [R6]
            timer_zero_edge_o   <= option_r[`CSOR_OP_EDGE_T0];     // [R6]
            weak_pullup_en_o    <= ~option_r[`CSOR_OP_PULLUP_DIS]; // [R6]
            direct_bank_o       <= status_r[`CSOR_ST_RP1:`CSOR_ST_RP0]; // [R12]
            indirect_bank_o     <= status_r[`CSOR_ST_IRP];              // [R12]
        end
    end

endmodule // csor_core_regs

/* csor_core_regs_assertions.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Port checks for the status and option register block.
// ----------------------------------------------------------------------------
module csor_core_regs_chk
(
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [5:0]  adr_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    input wire [8:0]  timer_div_o,
    input wire [7:0]  watchdog_div_o,
    input wire        ext_irq_edge_o,
    input wire        timer_zero_source_o,
    input wire        timer_zero_edge_o,
    input wire        weak_pullup_en_o,
    input wire [1:0]  direct_bank_o,
    input wire        indirect_bank_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // The follow checks lean on the read data standing until the next read.
    chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in the next cycle");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held for more than one cycle");
    chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without a request");
    chk_div_exclusive: assert property (timer_div_o == 9'h001 || watchdog_div_o == 8'h01)
        else $error("prescaler serves timer and watchdog at once");
    chk_timer_onehot: assert property ($onehot(timer_div_o))
        else $error("timer divide is not a power of two");
    chk_wdt_onehot: assert property ($onehot(watchdog_div_o))
        else $error("watchdog divide is not a power of two");
    chk_option_copy: assert property (ack_o && !$past(we_i) && $past(adr_i) == 6'h04 |=>
        {ext_irq_edge_o, timer_zero_source_o, timer_zero_edge_o, weak_pullup_en_o}
        == {dat_o[6:4], !dat_o[7]})
        else $error("option pins differ from option register");
    chk_div_follow: assert property (ack_o && !$past(we_i) && $past(adr_i) == 6'h04 |=>
        timer_div_o == (dat_o[3] ? 9'h001 : (9'h002 << dat_o[2:0])))
        else $error("timer divide differs from option register");
    chk_bank_follow: assert property (ack_o && !$past(we_i) && $past(adr_i) == 6'h00 |=>
        {indirect_bank_o, direct_bank_o} == dat_o[7:5])
        else $error("bank outputs differ from status register");

    cover property (ack_o && we_i);
    cover property (timer_div_o == 9'h100);
    cover property (watchdog_div_o == 8'h80);
endmodule // csor_core_regs_chk

bind csor_core_regs csor_core_regs_chk i_chk
(
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .timer_div_o(timer_div_o),
    .watchdog_div_o(watchdog_div_o), .ext_irq_edge_o(ext_irq_edge_o),
    .timer_zero_source_o(timer_zero_source_o), .timer_zero_edge_o(timer_zero_edge_o),
    .weak_pullup_en_o(weak_pullup_en_o), .direct_bank_o(direct_bank_o),
    .indirect_bank_o(indirect_bank_o)
);

/* test_core_status_option_regs.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Self-checking bench for the status and option registers.
// ----------------------------------------------------------------------------
module test_core_status_option_regs;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [5:0]  adr_i = 6'h00;
    logic [3:0]  sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0;
    logic        wdt_timeout_i = 1'b0;
    logic        sleep_i = 1'b0;
    logic        kick_i = 1'b0;
    wire  [31:0] dat_o;
    wire         ack_o;
    wire  [8:0]  timer_div_o;
    wire  [7:0]  watchdog_div_o;
    wire         irq_edge, t0_src, t0_edge, pull_en, ind_bank;
    wire  [1:0]  dir_bank;
    integer      n_mismatch = 0;
    integer      tests_run = 0;
    integer      seed = 32'h93c2578f;
    integer      i;
    logic [31:0] r;
    logic [31:0] exp_q[$];
    logic [7:0]  stat, opt, a, b, res, d;
    logic [8:0]  s9, a9;
    logic [4:0]  n5;
    logic [2:0]  op;

    csor_core_regs i_dut
    (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .wdt_timeout_i(wdt_timeout_i), .sleep_i(sleep_i), .watchdog_kick_instr_i(kick_i),
        .timer_div_o(timer_div_o), .watchdog_div_o(watchdog_div_o),
        .ext_irq_edge_o(irq_edge), .timer_zero_source_o(t0_src),
        .timer_zero_edge_o(t0_edge), .weak_pullup_en_o(pull_en),
        .direct_bank_o(dir_bank), .indirect_bank_o(ind_bank)
    );

    // The 125 MHz core clock.
    always #4 clk_i = ~clk_i;

    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] got);
        tests_run = tests_run + 1;
        if (got !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic w, input logic [5:0] ad, input logic [31:0] dt);
        integer n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= ad;
        dat_i <= dt;
        do
        begin
            @(posedge clk_i);
            n = n + 1;
        end
        while (ack_o !== 1'b1 && n < 16);
        if (n >= 16)
        begin
            n_mismatch = n_mismatch + 1;
            report_and_stop();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] ad, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, ad, 32'h0);
    endtask

    // Address bit 8 and data bit 0 share a field bit, so callers keep them equal.
    task automatic core_wr(input logic [8:0] ca, input logic [7:0] cd);
        wb(1'b1, 6'h08, {15'h0, 1'b1, cd, ca[7:0]});
    endtask

    // Derived outputs settle within three cycles of a register change.
    task automatic chk_pins;
        repeat (3) @(posedge clk_i);
        cmp("timer div", opt[3] ? 9'h001 : 9'h002 << opt[2:0], timer_div_o);
        cmp("wdt div", opt[3] ? 8'h01 << opt[2:0] : 8'h01, watchdog_div_o);
        cmp("option pins", {opt[6:4], ~opt[7]}, {irq_edge, t0_src, t0_edge, pull_en});
        cmp("banks", stat[7:5], {ind_bank, dir_bank});
    endtask

    // Every read answer is matched with the oldest noted expectation.
    always @(posedge clk_i)
        if (ack_o === 1'b1 && we_i === 1'b0)
            cmp("read data", exp_q.size() ? exp_q.pop_front() : 32'hx, dat_o);

    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        stat = 8'h18;
        opt = 8'hff;
        rd(6'h00, 32'h18);
        rd(6'h04, 32'hff);
        chk_pins();
        rd(6'h14, 32'h0001_0001);
        // Each rate with both assignments, over the bus and both mirrors.
        for (i = 0; i < 16; i++)
        begin
            r = $random(seed);
            opt = {r[7:4], i[3:0]};
            if (i[1])
                wb(1'b1, 6'h04, {24'h0, opt});
            else
                core_wr(i[0] ? 9'h181 : 9'h081, opt);
            rd(6'h04, {24'h0, opt});
            chk_pins();
        end
        // A write with its low byte lane off leaves the option register alone.
        sel_i <= 4'he;
        wb(1'b1, 6'h04, {24'h0, ~opt});
        sel_i <= 4'hf;
        rd(6'h04, {24'h0, opt});
        // All four status mirrors; the reset-cause bits must not move.
        for (i = 0; i < 4; i++)
        begin
            r = $random(seed);
            a9 = {i[1:0], 7'h03};
            d = {r[7:1], a9[8]};
            core_wr(a9, d);
            stat = {d[7:5], stat[4:3], d[2:0]};
            rd(6'h00, {24'h0, stat});
            chk_pins();
        end
        wb(1'b1, 6'h00, 32'hff);
        wb(1'b1, 6'h18, 32'hff);
        rd(6'h00, {24'h0, stat});
        rd(6'h18, 32'h0);
        // Watchdog timeout, sleep, then kick.
        for (i = 0; i < 3; i++)
        begin
            @(posedge clk_i);
            wdt_timeout_i <= (i == 0);
            sleep_i <= (i == 1);
            kick_i <= (i == 2);
            @(posedge clk_i);
            {wdt_timeout_i, sleep_i, kick_i} <= 3'b000;
            stat[4:3] = (i == 0) ? {1'b0, stat[3]} : {1'b1, i[1]};
            rd(6'h00, {24'h0, stat});
        end
        // Every operation, with zero and equal operands among the cases.
        for (i = 0; i < 15; i++)
        begin
            r = $random(seed);
            op = i % 5;
            a = r[7:0];
            b = (i < 5) ? 8'h00 : (i == 6) ? a : r[15:8];
            s9 = (op == 3'h1) ? {1'b0, a} + {1'b0, ~b} + 9'h1 : {1'b0, a} + {1'b0, b};
            n5 = (op == 3'h1) ? a[3:0] + {1'b0, ~b[3:0]} + 5'h1 : a[3:0] + b[3:0];
            res = (op == 3'h2) ? {a[6:0], stat[0]} : (op == 3'h3) ? {stat[0], a[7:1]} :
                  (op == 3'h4) ? a & b : s9[7:0];
            wb(1'b1, 6'h0c, {7'h0, 1'b1, 5'h0, op, b, a});
            stat[2] = (res == 8'h00);
            if (op < 3'h2)
                stat[1:0] = {n5[4], s9[8]};
            else if (op < 3'h4)
                stat[0] = (op == 3'h2) ? a[7] : a[0];
            rd(6'h10, {24'h0, res});
            rd(6'h00, {24'h0, stat});
        end
        report_and_stop();
    end
endmodule // test_core_status_option_regs
